/* File: dv/cpu_model.sv */
// processor model: executed fetches, data accesses, interrupt pulses
module cpu_model (
    input wire logic clk,
    output event_pkg::cpu_activity_s cpu
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: valids low, address lines scrambled so stale values never look live
    task idle;
        cpu.exec_valid = 1'b0;
        cpu.exec_addr = ~cpu.exec_addr;
        cpu.bus_valid = 1'b0;
        cpu.bus_write = ~cpu.bus_write;
        cpu.bus_addr = ~cpu.bus_addr;
        cpu.irq_entry = 1'b0;
        cpu.irq_exit = 1'b0;
    endtask : idle

    // start quiet
    initial begin
        cpu = '0;
        idle;
    end

    // one cycle of activity; exec valid only for executed, never queued, fetches
    task act(input logic e, input logic [23:0] ea, input logic b, input logic w,
             input logic [23:0] ba, input logic ie, input logic ix);
        @(posedge clk);
        #1;
        cpu = {e, ea, b, w, ba, ie, ix};
        @(posedge clk);
        #1;
        idle;
    endtask : act
endmodule : cpu_model

/* File: dv/event_combiner_sva.sv */
// checker for the event combiner: hit timing, modes, break delay
module event_combiner_sva #(
    parameter int n_evt = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire event_pkg::cpu_activity_s cpu,
    input wire event_pkg::event_cfg_s [n_evt-1:0] ev_cfg,
    input wire event_pkg::comb_cfg_s comb_cfg,
    input wire logic cfg_load,
    input wire logic [n_evt-1:0] event_hit,
    input wire logic cond,
    input wire logic break_req,
    input wire logic break_pending,
    input wire logic [2:0] seq_step,
    input wire logic [1:0] st_state
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [n_evt-1:0] en_mask; // detectors in use

    // gather enable bits for the simultaneous check
    always_comb begin
        for (int i = 0; i < n_evt; i++) begin
            en_mask[i] = ev_cfg[i].enable;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // condition raised while no delay runs and config is untouched
    sequence s_cond_idle;
        cond && !break_pending && !cfg_load;
    endsequence
    // two cycles of pending, then the request as pending drops
    sequence s_wait2;
        break_pending ##1 break_pending ##1 (break_req && !break_pending);
    endsequence

    property p_fetch;
        ev_cfg[0].enable && ev_cfg[0].kind == event_pkg::kind_fetch && cpu.exec_valid
            && cpu.exec_addr == ev_cfg[0].addr_lo && !cfg_load |=> event_hit[0];
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch hit missing");
    property p_off;
        !ev_cfg[2].enable |=> !event_hit[2];
    endproperty
    a_off: assert property (p_off) else $error("disabled detector hit");
    property p_or;
        comb_cfg.mode == event_pkg::mode_or && (|event_hit) && !cfg_load |=> cond;
    endproperty
    a_or: assert property (p_or) else $error("or condition missing");
    property p_sim;
        comb_cfg.mode == event_pkg::mode_and_sim && cond |-> $past(event_hit) == $past(en_mask);
    endproperty
    a_sim: assert property (p_sim) else $error("simultaneous condition without all hits");
    property p_seq;
        comb_cfg.mode == event_pkg::mode_seq && cond |-> $past(seq_step) == comb_cfg.seq_len - 3'h1;
    endproperty
    a_seq: assert property (p_seq) else $error("sequence completed early");
    property p_range;
        seq_step < 3'h6 && st_state <= event_pkg::st_state_max;
    endproperty
    a_range: assert property (p_range) else $error("step or state out of range");
    property p_delay0;
        (s_cond_idle ##0 comb_cfg.break_delay == 16'h0000) |=> break_req;
    endproperty
    a_delay0: assert property (p_delay0) else $error("undelayed break late");
    property p_delay2;
        (s_cond_idle ##0 comb_cfg.break_delay == 16'h0002) |=> s_wait2;
    endproperty
    a_delay2: assert property (p_delay2) else $error("delayed break wrong");
    property p_req_cause;
        break_req |-> $past(cond) || $past(break_pending);
    endproperty
    a_req_cause: assert property (p_req_cause) else $error("break without cause");
    property p_clear;
        cfg_load |=> !break_pending && seq_step == 3'h0 && st_state == 2'h0 && event_hit == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("progress kept over rewrite");
endmodule : event_combiner_sva

/* File: dv/testbench.sv */
// top bench for the event combiner with processor model and checker
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, trig_pin, cfg_load;
    event_pkg::cpu_activity_s cpu;
    event_pkg::event_cfg_s [15:0] ev_cfg; // never more than sixteen definitions
    event_pkg::comb_cfg_s comb_cfg;
    logic [15:0] event_hit;
    logic cond, break_req, break_pending;
    logic [2:0] seq_step;
    logic [1:0] st_state;
    int n_mismatch, total_checks;
    localparam logic [23:0] fa = 24'h000100; // fetch address
    localparam logic [23:0] da = 24'h002004; // inside the data range

    event_combiner #(.n_evt(16)) uut (.clk(clk), .rst(rst), .cpu(cpu), .trig_pin(trig_pin),
        .ev_cfg(ev_cfg), .comb_cfg(comb_cfg), .cfg_load(cfg_load), .event_hit(event_hit),
        .cond(cond), .break_req(break_req), .break_pending(break_pending),
        .seq_step(seq_step), .st_state(st_state));
    cpu_model m (.clk(clk), .cpu(cpu));

    // free running clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task tick;
        @(posedge clk);
        #1;
    endtask : tick
    // new mode with a one-cycle rewrite pulse
    task load(input event_pkg::comb_mode_e md);
        tick;
        comb_cfg.mode = md;
        cfg_load = 1'b1;
        tick;
        cfg_load = 1'b0;
    endtask : load
    // one detector; range of sixteen bytes, reads only
    task det(input int i, input event_pkg::event_kind_e k, input logic [23:0] lo);
        ev_cfg[i] = '0;
        ev_cfg[i].enable = 1'b1;
        ev_cfg[i].kind = k;
        ev_cfg[i].addr_lo = lo;
        ev_cfg[i].addr_hi = lo + 24'h00000f;
        ev_cfg[i].range_en = 1'b1;
        ev_cfg[i].on_read = 1'b1;
        ev_cfg[i].on_irq_entry = 1'b1;
        ev_cfg[i].on_irq_exit = 1'b1;
        ev_cfg[i].trig_level = 1'b1;
    endtask : det
    task results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    // every kind of detector under or, fetch events added as or
    task t_kinds;
        load(event_pkg::mode_or);
        m.act(0, fa, 0, 0, 0, 0, 0);
        `CHK(event_hit, 16'h0000)
        m.act(1, fa, 0, 0, 0, 0, 0);
        `CHK(event_hit, 16'h8001)
        tick;
        `CHK(cond, 1'b1)
        tick;
        `CHK(break_req, 1'b1)
        m.act(0, 0, 1, 0, 24'h002000, 0, 0);
        `CHK(event_hit, 16'h0002)
        m.act(0, 0, 1, 0, 24'h00200f, 0, 0);
        `CHK(event_hit, 16'h0002)
        m.act(0, 0, 1, 1, da, 0, 0);
        `CHK(event_hit, 16'h0000)
        m.act(0, 0, 1, 0, 24'h002010, 0, 0);
        `CHK(event_hit, 16'h0000)
        m.act(0, 0, 0, 0, 0, 1, 0);
        `CHK(event_hit, 16'h0004)
        m.act(0, 0, 0, 0, 0, 0, 1);
        `CHK(event_hit, 16'h0004)
        trig_pin = 1'b1;
        for (int k = 0; k < 8 && event_hit[3] !== 1'b1; k++) tick;
        `CHK(event_hit, 16'h0008)
        if (event_hit !== 16'h0008) results;
        // let the pulse reach the combiner while its detector is still enabled
        tick;
        ev_cfg[2].enable = 1'b0;
        ev_cfg[3].enable = 1'b0;
    endtask : t_kinds

    // break three cycles after the condition, two of them pending
    task t_delay;
        // delay changed only after the rewrite, so no earlier condition starts it
        load(event_pkg::mode_or);
        comb_cfg.break_delay = 16'h0002;
        m.act(1, fa, 0, 0, 0, 0, 0);
        tick;
        `CHK(cond, 1'b1)
        for (int k = 0; k < 3; k++) begin
            tick;
            `CHK({break_pending, break_req}, (k < 2) ? 2'b10 : 2'b01)
        end
        comb_cfg.break_delay = 16'h0000;
    endtask : t_delay

    // accumulation, simultaneous and subroutine modes
    task t_and_sub;
        load(event_pkg::mode_and_acc);
        m.act(0, 0, 1, 0, da, 0, 0);
        tick;
        `CHK(cond, 1'b0)
        m.act(1, fa, 0, 0, 0, 0, 0);
        tick;
        `CHK(cond, 1'b1)
        m.act(0, 0, 1, 0, da, 0, 0);
        load(event_pkg::mode_and_acc);
        m.act(1, fa, 0, 0, 0, 0, 0);
        tick;
        `CHK(cond, 1'b0)
        load(event_pkg::mode_and_sim);
        m.act(1, fa, 0, 0, 0, 0, 0);
        tick;
        `CHK(cond, 1'b0)
        m.act(1, fa, 1, 0, da, 0, 0);
        tick;
        `CHK(cond, 1'b1)
        comb_cfg.sub_evt = 4'h1;
        comb_cfg.sub_lo = 24'h000100;
        comb_cfg.sub_hi = 24'h0001ff;
        load(event_pkg::mode_sub);
        m.act(1, 24'h000300, 0, 0, 0, 0, 0);
        m.act(0, 0, 1, 0, da, 0, 0);
        tick;
        `CHK(cond, 1'b0)
        m.act(1, 24'h000180, 0, 0, 0, 0, 0);
        m.act(0, 0, 1, 0, da, 0, 0);
        tick;
        `CHK(cond, 1'b1)
    endtask : t_and_sub

    // data then fetch in order; rewrite clears a half-done sequence
    task t_seq;
        comb_cfg.seq_len = 3'h2;
        comb_cfg.seq_evt[0] = 4'h1;
        comb_cfg.seq_evt[1] = 4'h0;
        load(event_pkg::mode_seq);
        m.act(1, fa, 0, 0, 0, 0, 0);
        tick;
        `CHK({cond, seq_step}, 4'h0)
        m.act(0, 0, 1, 0, da, 0, 0);
        tick;
        `CHK({cond, seq_step}, 4'h1)
        m.act(1, fa, 0, 0, 0, 0, 0);
        tick;
        `CHK({cond, seq_step}, 4'h8)
        m.act(0, 0, 1, 0, da, 0, 0);
        load(event_pkg::mode_seq);
        `CHK(seq_step, 3'h0)
        // reset point on the fetch detector outranks the final step
        m.act(0, 0, 1, 0, da, 0, 0);
        comb_cfg.seq_rst_en = 1'b1;
        comb_cfg.seq_rst_evt = 4'hf;
        m.act(1, fa, 0, 0, 0, 0, 0);
        tick;
        `CHK({cond, seq_step}, 4'h0)
        comb_cfg.seq_rst_en = 1'b0;
    endtask : t_seq

    // state 0 to 1 on data, 1 to 2 on fetch, entry into 2 meets the condition
    task t_state;
        comb_cfg.paths = '0;
        comb_cfg.paths[0] = {1'b1, 2'h0, 2'h1, 4'h1};
        comb_cfg.paths[1] = {1'b1, 2'h1, 2'h2, 4'h0};
        comb_cfg.st_accept = 2'h2;
        load(event_pkg::mode_state);
        m.act(1, fa, 0, 0, 0, 0, 0);
        tick;
        `CHK({cond, st_state}, 3'h0)
        m.act(0, 0, 1, 0, da, 0, 0);
        tick;
        `CHK({cond, st_state}, 3'h1)
        m.act(1, fa, 0, 0, 0, 0, 0);
        tick;
        `CHK({cond, st_state}, 3'h6)
    endtask : t_state

    // main sequence
    initial begin
        rst = 1'b1;
        trig_pin = 1'b0;
        cfg_load = 1'b0;
        comb_cfg = '0;
        ev_cfg = '0;
        n_mismatch = 0;
        total_checks = 0;
        det(0, event_pkg::kind_fetch, fa);
        det(1, event_pkg::kind_data, 24'h002000);
        det(2, event_pkg::kind_irq, 24'h000000);
        det(3, event_pkg::kind_trig, 24'h000000);
        det(15, event_pkg::kind_fetch, fa);
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        t_kinds;
        t_delay;
        t_and_sub;
        t_seq;
        t_state;
        results;
    end
endmodule : testbench

bind event_combiner event_combiner_sva #(.n_evt(n_evt)) chk (.clk(clk), .rst(rst), .cpu(cpu),
    .ev_cfg(ev_cfg), .comb_cfg(comb_cfg), .cfg_load(cfg_load), .event_hit(event_hit), .cond(cond),
    .break_req(break_req), .break_pending(break_pending), .seq_step(seq_step), .st_state(st_state));

/* File: hdl/event_combiner.sv */
// sixteen event detectors, condition combiner and delayed break request
//
// Functional notes
// - sixteen detectors, any kind, all active together
// - fetch event fires on executed address match
// - queue prefetches never qualify a fetch event
// - data access on address/range plus qualifier
// - interrupt entry and exit both detectable
// - trigger fires once when input enters configured state
// - exactly one combination mode selected
// - or: any enabled event fires
// - accumulated and: all enabled seen, any order
// - simultaneous and: all enabled in one cycle
// - subroutine: designated event inside address range
// - sequential: events fire in configured order
// - state mode: event driven configurable transitions
// - sequencer: six forward steps plus reset point
// - three states, nine paths, plus reset point
// - break after 0..65535 cycle delay, default zero
module event_combiner #(
    parameter int n_evt = event_pkg::n_events
) (
    input wire logic clk,
    input wire logic rst,
    input wire event_pkg::cpu_activity_s cpu,
    input wire logic trig_pin,
    input wire event_pkg::event_cfg_s [n_evt-1:0] ev_cfg,
    input wire event_pkg::comb_cfg_s comb_cfg,
    input wire logic cfg_load,
    output logic [n_evt-1:0] event_hit,
    output logic cond,
    output logic break_req,
    output logic break_pending,
    output logic [2:0] seq_step,
    output logic [1:0] st_state
);

    // all combiner state
    typedef struct packed {
        logic trig_s1;                              // synchroniser first stage
        logic trig_s2;                              // synchroniser second stage
        logic [n_evt-1:0] acc;                      // accumulated and memory
        logic [2:0] step;                           // sequencer position
        logic [1:0] state;                          // state mode position
        logic [event_pkg::addr_w-1:0] pc;           // last executed address
        logic cond;                                 // combined condition pulse
        logic busy;                                 // break delay running
        logic [event_pkg::delay_w-1:0] cnt;         // break delay countdown
        logic brk;                                  // break request pulse
    } comb_state_s;

    comb_state_s st;
    comb_state_s next_st;
    logic [n_evt-1:0] hit;       // detector pulses
    logic [n_evt-1:0] en;        // enabled detectors
    logic [n_evt-1:0] en_hit;    // pulses of enabled detectors only
    logic [n_evt-1:0] acc_all;   // accumulated plus this cycle
    logic any_en;                // at least one detector in use
    logic in_sub;                // execution inside subroutine range
    logic seq_adv;               // current step's event fired
    logic seq_rst;               // sequencer reset point fired
    logic st_rst;                // state reset point fired
    logic st_take;               // a path fires this cycle
    logic [1:0] st_to;           // destination of the firing path
    logic c;                     // condition this cycle

    // one detector per slot, each free to watch any kind
    for (genvar i = 0; i < n_evt; i++) begin : g_det
        event_detector u_det (
            .clk(clk),
            .rst(rst),
            .clear(cfg_load),
            .cfg(ev_cfg[i]),
            .cpu(cpu),
            .trig(st.trig_s2),
            .match(hit[i])
        );
        assign en[i] = ev_cfg[i].enable;
    end

    // combination, progress tracking and break delay
    always_comb begin
        next_st = st;
        en_hit = hit & en;
        any_en = |en;
        acc_all = st.acc | en_hit;
        in_sub = (st.pc >= comb_cfg.sub_lo) && (st.pc <= comb_cfg.sub_hi);
        seq_adv = 1'b0;
        seq_rst = comb_cfg.seq_rst_en && hit[comb_cfg.seq_rst_evt];
        st_rst = comb_cfg.st_rst_en && hit[comb_cfg.st_rst_evt];
        st_take = 1'b0;
        st_to = st.state;
        c = 1'b0;

        // trigger pin crosses in through two flops
        next_st.trig_s1 = trig_pin;
        next_st.trig_s2 = st.trig_s1;

        // track the executing address for the subroutine range
        if (cpu.exec_valid) begin
            next_st.pc = cpu.exec_addr;
        end

        // lowest numbered matching path wins when several fire together
        for (int p = event_pkg::st_paths - 1; p >= 0; p--) begin
            if (comb_cfg.paths[p].valid && (comb_cfg.paths[p].from_state == st.state) &&
                hit[comb_cfg.paths[p].evt] && (comb_cfg.paths[p].to_state <= event_pkg::st_state_max)) begin
                st_take = 1'b1;
                st_to = comb_cfg.paths[p].to_state;
            end
        end

        // a single selected mode drives the condition
        case (comb_cfg.mode)
            event_pkg::mode_or: begin
                c = |en_hit;
            end
            event_pkg::mode_and_acc: begin
                // rearm after meeting so the condition pulses once per round
                if (any_en && ((acc_all & en) == en)) begin
                    c = 1'b1;
                    next_st.acc = '0;
                end else begin
                    next_st.acc = acc_all;
                end
            end
            event_pkg::mode_and_sim: begin
                c = any_en && (en_hit == en);
            end
            event_pkg::mode_sub: begin
                c = hit[comb_cfg.sub_evt] && in_sub;
            end
            event_pkg::mode_seq: begin
                if (comb_cfg.seq_len != 3'h0 && st.step < 3'(event_pkg::seq_steps)) begin
                    seq_adv = hit[comb_cfg.seq_evt[st.step]];
                end
                // reset point outranks a step taken in the same cycle
                if (seq_rst) begin
                    next_st.step = event_pkg::step_reset;
                end else if (seq_adv) begin
                    if (st.step + 3'h1 >= comb_cfg.seq_len) begin
                        c = 1'b1;
                        next_st.step = event_pkg::step_reset;
                    end else begin
                        next_st.step = st.step + 3'h1;
                    end
                end
            end
            event_pkg::mode_state: begin
                if (st_rst) begin
                    next_st.state = event_pkg::st_state_reset;
                end else if (st_take) begin
                    next_st.state = st_to;
                    c = (st_to == comb_cfg.st_accept);
                end
            end
            default: begin
                c = 1'b0;
            end
        endcase

        // rewriting the configuration restarts all progress
        if (cfg_load) begin
            next_st.acc = '0;
            next_st.step = event_pkg::step_reset;
            next_st.state = event_pkg::st_state_reset;
            c = 1'b0;
        end
        next_st.cond = c;

        // delay from the registered condition to the break request;
        // a condition met while a delay runs does not restart it
        next_st.brk = 1'b0;
        if (st.busy) begin
            if (st.cnt == 16'h0001) begin
                next_st.busy = 1'b0;
                next_st.brk = 1'b1;
            end
            next_st.cnt = st.cnt - 16'h0001;
        end else if (st.cond) begin
            if (comb_cfg.break_delay == event_pkg::delay_reset) begin
                next_st.brk = 1'b1;
            end else begin
                next_st.busy = 1'b1;
                next_st.cnt = comb_cfg.break_delay;
            end
        end
        if (cfg_load) begin
            next_st.busy = 1'b0;
            next_st.cnt = event_pkg::delay_reset;
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st.trig_s1 <= 1'b0;
            st.trig_s2 <= 1'b0;
            st.acc <= '0;
            st.step <= event_pkg::step_reset;
            st.state <= event_pkg::st_state_reset;
            st.pc <= event_pkg::addr_reset;
            st.cond <= 1'b0;
            st.busy <= 1'b0;
            st.cnt <= event_pkg::delay_reset;
            st.brk <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign event_hit = hit;
    assign cond = st.cond;
    assign break_req = st.brk;
    assign break_pending = st.busy;
    assign seq_step = st.step;
    assign st_state = st.state;

endmodule : event_combiner

/* File: hdl/event_detector.sv */
// one event detector producing a registered one-clock match pulse
module event_detector (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire event_pkg::event_cfg_s cfg,
    input wire event_pkg::cpu_activity_s cpu,
    input wire logic trig,
    output logic match
);

    // all detector state
    typedef struct packed {
        logic match;       // registered hit pulse
        logic trig_prev;   // trigger matched last cycle
    } det_state_s;

    det_state_s st;
    det_state_s next_st;
    logic trig_eq;         // trigger at configured state
    logic addr_hit;        // data address compare

    // combinational match per kind
    always_comb begin
        next_st = st;
        trig_eq = (trig == cfg.trig_level);
        if (cfg.range_en) begin
            addr_hit = (cpu.bus_addr >= cfg.addr_lo) && (cpu.bus_addr <= cfg.addr_hi);
        end else begin
            addr_hit = (cpu.bus_addr == cfg.addr_lo);
        end
        next_st.trig_prev = trig_eq;
        next_st.match = 1'b0;
        if (cfg.enable && !clear) begin
            case (cfg.kind)
                event_pkg::kind_fetch: begin
                    // exec strobe only; queue prefetches never reach this port
                    next_st.match = cpu.exec_valid && (cpu.exec_addr == cfg.addr_lo);
                end
                event_pkg::kind_data: begin
                    next_st.match = cpu.bus_valid && addr_hit &&
                        ((cpu.bus_write && cfg.on_write) || (!cpu.bus_write && cfg.on_read));
                end
                event_pkg::kind_irq: begin
                    next_st.match = (cpu.irq_entry && cfg.on_irq_entry) ||
                        (cpu.irq_exit && cfg.on_irq_exit);
                end
                event_pkg::kind_trig: begin
                    // fire on entering the state, so a held level gives one pulse
                    next_st.match = trig_eq && !st.trig_prev;
                end
                default: begin
                    next_st.match = 1'b0;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign match = st.match;

endmodule : event_detector

/* File: hdl/event_pkg.sv */
// shared types and constants for the debug event detect and combine logic
package event_pkg;

    localparam int addr_w = 24;        // processor address width
    localparam int n_events = 16;      // detectors available at once
    localparam int evt_idx_w = 4;      // width of an event index
    localparam int seq_steps = 6;      // forward steps of the sequencer
    localparam int st_paths = 9;       // transition paths of the state mode
    localparam int delay_w = 16;       // break delay counter width, 0..65535
    localparam logic [delay_w-1:0] delay_reset = 16'h0000;   // default break delay
    localparam logic [addr_w-1:0] addr_reset = 24'h000000;   // pc tracker after reset
    localparam logic [2:0] step_reset = 3'h0;                // sequencer start
    localparam logic [1:0] st_state_reset = 2'h0;            // state machine start state
    localparam logic [1:0] st_state_max = 2'h2;              // three states: 0, 1, 2

    // kind of occurrence a detector watches
    typedef enum logic [1:0] {
        kind_fetch = 2'b00,
        kind_data = 2'b01,
        kind_irq = 2'b10,
        kind_trig = 2'b11
    } event_kind_e;

    // combination applied over the enabled events
    typedef enum logic [2:0] {
        mode_off = 3'b000,
        mode_or = 3'b001,
        mode_and_acc = 3'b010,
        mode_and_sim = 3'b011,
        mode_sub = 3'b100,
        mode_seq = 3'b101,
        mode_state = 3'b110
    } comb_mode_e;

    // per detector configuration
    typedef struct packed {
        logic enable;                 // detector in use
        event_kind_e kind;            // what it watches
        logic [addr_w-1:0] addr_lo;   // single address, or range low end
        logic [addr_w-1:0] addr_hi;   // range high end, inclusive
        logic range_en;               // data access compares a range
        logic on_read;                // data access qualifier: reads count
        logic on_write;               // data access qualifier: writes count
        logic on_irq_entry;           // interrupt servicing start counts
        logic on_irq_exit;            // interrupt return counts
        logic trig_level;             // trigger state that fires
    } event_cfg_s;

    // processor side activity, all on clk
    typedef struct packed {
        logic exec_valid;             // an instruction is executed this cycle
        logic [addr_w-1:0] exec_addr; // address of the executed instruction
        logic bus_valid;              // data bus access this cycle
        logic bus_write;              // access is a write
        logic [addr_w-1:0] bus_addr;  // data access address
        logic irq_entry;              // interrupt servicing begins
        logic irq_exit;               // return from interrupt servicing
    } cpu_activity_s;

    // one transition path of the state mode
    typedef struct packed {
        logic valid;
        logic [1:0] from_state;
        logic [1:0] to_state;
        logic [evt_idx_w-1:0] evt;
    } st_path_s;

    // combination configuration
    typedef struct packed {
        comb_mode_e mode;
        logic [evt_idx_w-1:0] sub_evt;          // designated event for subroutine mode
        logic [addr_w-1:0] sub_lo;              // subroutine range low
        logic [addr_w-1:0] sub_hi;              // subroutine range high
        logic [2:0] seq_len;                    // steps in use, 1..6
        logic [seq_steps-1:0][evt_idx_w-1:0] seq_evt;
        logic seq_rst_en;                       // sequencer reset point in use
        logic [evt_idx_w-1:0] seq_rst_evt;
        st_path_s [st_paths-1:0] paths;
        logic st_rst_en;                        // state mode reset point in use
        logic [evt_idx_w-1:0] st_rst_evt;
        logic [1:0] st_accept;                  // state whose entry meets the condition
        logic [delay_w-1:0] break_delay;        // bus cycles from condition to break
    } comb_cfg_s;

endpackage : event_pkg
